// *** pkg/gpw_map.vh ***
`ifndef GPW_MAP_VH
`define GPW_MAP_VH

// ==========================================================================
// Register byte offsets on the APB word map.
// ==========================================================================
`define GPW_OFF_DATA 12'h000
`define GPW_OFF_DIR 12'h004
`define GPW_OFF_PULLUP 12'h008
`define GPW_OFF_FUNC 12'h00c
`define GPW_OFF_PIN_LEVEL 12'h010
`define GPW_OFF_CONFLICT 12'h014

// ==========================================================================
// Widths and decode span.
// ==========================================================================
`define GPW_ADDR_W 12
`define GPW_PORT_W 8

// ==========================================================================
// Reset and read-back values.
// ==========================================================================
`define GPW_RST_DATA 8'h00
`define GPW_RST_DIR 8'h00
`define GPW_RST_PULLUP 8'h00
`define GPW_RST_FUNC 8'h00
`define GPW_RST_CONFLICT 8'h00
`define GPW_DIR_READ 8'hff
`define GPW_WAKE_IDLE 8'hff
`define GPW_RDATA_ZERO 32'h0000_0000

`endif

// *** hdl/gpw_pin_cell.v ***
`timescale 1ns/1ps

// ==========================================================================
// One port pin: steering of driver, pull-up, wake path and read-back.
// ==========================================================================
module gpw_pin_cell (
  input wire dir_bit,
  input wire latch_bit,
  input wire pullup_bit,
  input wire func_bit,
  input wire pin_level,
  output reg nxt_out,
  output reg nxt_oe,
  output reg nxt_pullup,
  output reg nxt_wake,
  output reg rd_bit
);

  // Combinational pin steering; the parent registers every result.
  always @* begin
    if (func_bit) begin
      nxt_oe = 1'b0;
      nxt_out = 1'b0;
      nxt_wake = pin_level;
    end else begin
      nxt_oe = dir_bit;
      nxt_out = dir_bit & latch_bit;
      nxt_wake = 1'b1; // Idle level of an unused wake line.
    end
    nxt_pullup = ~dir_bit & pullup_bit;
    rd_bit = dir_bit ? latch_bit : pin_level;
  end

endmodule // gpw_pin_cell

// *** hdl/gpw_port.v ***
// Overview of operation
// - Data read returns latch value for bits whose direction bit is 1.
// - Data read returns sampled pin level for bits whose direction bit is 0.
// - Direction bit 1 drives the latched data out; 0 makes the pin an input.
// - Direction register is write-only and always reads back as all ones.
// - Direction and latch drive a pin only in general I/O use; direction still gates the pull-up in wake-up use.
// - Pull-up enable only when direction is 0 and pull-up bit is 1.
// - Function bit 0 selects general I/O, 1 selects wake-up input.
// - A wake-up pin forwards its level to the wake-up interrupt input.
// - After reset every pull-up enable output is deasserted.
`timescale 1ns/1ps
`include "gpw_map.vh"

module gpw_port #(
  parameter PORT_W = `GPW_PORT_W,
  parameter ADDR_W = `GPW_ADDR_W
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [PORT_W-1:0] gp_pin_n_in,
  output reg [PORT_W-1:0] gp_pin_n_out,
  output reg [PORT_W-1:0] gp_pin_n_oe,
  output reg [PORT_W-1:0] pullup_en,
  output reg [PORT_W-1:0] wake_input_n
);

  // ========================================================================
  // Bus handshake states.
  // ========================================================================
  localparam ST_IDLE = 1'b0;
  localparam ST_ACK = 1'b1;

  // ========================================================================
  // Address decode helpers.
  // ========================================================================

  // True when the address hits one of the mapped words.
  function is_mapped;
    input [ADDR_W-1:0] addr;
    begin
      case (addr)
        `GPW_OFF_DATA,
        `GPW_OFF_DIR,
        `GPW_OFF_PULLUP,
        `GPW_OFF_FUNC,
        `GPW_OFF_PIN_LEVEL,
        `GPW_OFF_CONFLICT: begin
          is_mapped = 1'b1;
        end
        default: begin
          is_mapped = 1'b0;
        end
      endcase
    end
  endfunction

  // True when the address matches a given offset.
  function hit;
    input [ADDR_W-1:0] addr;
    input [ADDR_W-1:0] off;
    begin
      hit = (addr == off);
    end
  endfunction

  // ========================================================================
  // Software registers.
  // ========================================================================
  reg [PORT_W-1:0] pin_data_latch_ff;
  reg [PORT_W-1:0] pin_direction_ctrl_ff;
  reg [PORT_W-1:0] pin_pullup_ctrl_ff;
  reg [PORT_W-1:0] pin_function_select_ff;
  reg [PORT_W-1:0] conflict_sticky_ff;
  reg state_ff;

  reg [PORT_W-1:0] nxt_pin_data_latch;
  reg [PORT_W-1:0] nxt_pin_direction_ctrl;
  reg [PORT_W-1:0] nxt_pin_pullup_ctrl;
  reg [PORT_W-1:0] nxt_pin_function_select;
  reg [PORT_W-1:0] nxt_conflict_sticky;
  reg nxt_state;
  reg [31:0] nxt_prdata;
  reg nxt_pready;
  reg nxt_pslverr;

  // ========================================================================
  // Per-pin steering.
  // ========================================================================
  wire [PORT_W-1:0] cell_out;
  wire [PORT_W-1:0] cell_oe;
  wire [PORT_W-1:0] cell_pullup;
  wire [PORT_W-1:0] cell_wake;
  wire [PORT_W-1:0] cell_rd;

  // One steering cell per pin keeps each bit independent of its neighbours.
  genvar gi;
  generate
    for (gi = 0; gi < PORT_W; gi = gi + 1) begin : g_pin
      gpw_pin_cell u_cell (
        .dir_bit(pin_direction_ctrl_ff[gi]),
        .latch_bit(pin_data_latch_ff[gi]),
        .pullup_bit(pin_pullup_ctrl_ff[gi]),
        .func_bit(pin_function_select_ff[gi]),
        .pin_level(gp_pin_n_in[gi]),
        .nxt_out(cell_out[gi]),
        .nxt_oe(cell_oe[gi]),
        .nxt_pullup(cell_pullup[gi]),
        .nxt_wake(cell_wake[gi]),
        .rd_bit(cell_rd[gi])
      );
    end
  endgenerate

  // ========================================================================
  // Bus phase decode.
  // ========================================================================
  wire setup_phase;
  wire access_done;
  wire wr_commit;
  wire lane0;
  wire [PORT_W-1:0] wdata_byte;
  wire [PORT_W-1:0] conflict_now;

  // The slave answers on the first access edge, so the access phase lasts one cycle.
  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & pready;
  // Only byte lane zero carries register bits; other lanes are ignored.
  assign lane0 = pstrb[0];
  assign wdata_byte = pwdata[PORT_W-1:0];
  assign wr_commit = access_done & pwrite & is_mapped(paddr) & lane0;

  // A pin with both output direction and wake function set is a prohibited mix.
  assign conflict_now = pin_direction_ctrl_ff & pin_function_select_ff;

  // ========================================================================
  // Read data multiplexer, evaluated in the setup cycle.
  // ========================================================================
  always @* begin
    nxt_prdata = `GPW_RDATA_ZERO;
    case (paddr)
      `GPW_OFF_DATA: begin
        nxt_prdata[PORT_W-1:0] = cell_rd;
      end
      `GPW_OFF_DIR: begin
        nxt_prdata[PORT_W-1:0] = `GPW_DIR_READ;
      end
      `GPW_OFF_PULLUP: begin
        nxt_prdata[PORT_W-1:0] = pin_pullup_ctrl_ff;
      end
      `GPW_OFF_FUNC: begin
        nxt_prdata[PORT_W-1:0] = pin_function_select_ff;
      end
      `GPW_OFF_PIN_LEVEL: begin
        // Raw pin levels regardless of direction, for board diagnostics.
        nxt_prdata[PORT_W-1:0] = gp_pin_n_in;
      end
      `GPW_OFF_CONFLICT: begin
        nxt_prdata[PORT_W-1:0] = conflict_sticky_ff;
      end
      default: begin
        nxt_prdata = `GPW_RDATA_ZERO;
      end
    endcase
  end

  // ========================================================================
  // Handshake state machine.
  // ========================================================================

  // Answer is prepared in the setup cycle so pready and prdata leave flops.
  always @* begin
    nxt_state = state_ff;
    nxt_pready = 1'b0;
    nxt_pslverr = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (setup_phase) begin
          nxt_state = ST_ACK;
          nxt_pready = 1'b1;
          nxt_pslverr = ~is_mapped(paddr);
        end
      end
      ST_ACK: begin
        // The transfer completes at this edge; a new setup may follow at once.
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // ========================================================================
  // Register write path.
  // ========================================================================
  always @* begin
    nxt_pin_data_latch = pin_data_latch_ff;
    nxt_pin_direction_ctrl = pin_direction_ctrl_ff;
    nxt_pin_pullup_ctrl = pin_pullup_ctrl_ff;
    nxt_pin_function_select = pin_function_select_ff;
    if (wr_commit) begin
      // The latch is written even for input pins, so a later switch to output
      // drives the value software prepared rather than a stale one.
      if (hit(paddr, `GPW_OFF_DATA)) begin
        nxt_pin_data_latch = wdata_byte;
      end
      if (hit(paddr, `GPW_OFF_DIR)) begin
        nxt_pin_direction_ctrl = wdata_byte;
      end
      if (hit(paddr, `GPW_OFF_PULLUP)) begin
        nxt_pin_pullup_ctrl = wdata_byte;
      end
      if (hit(paddr, `GPW_OFF_FUNC)) begin
        nxt_pin_function_select = wdata_byte;
      end
    end
  end

  // ========================================================================
  // Conflict flags: set by hardware, cleared by writing ones.
  // ========================================================================
  always @* begin
    nxt_conflict_sticky = conflict_sticky_ff;
    if (wr_commit && hit(paddr, `GPW_OFF_CONFLICT)) begin
      nxt_conflict_sticky = conflict_sticky_ff & ~wdata_byte;
    end
    // A conflict present in the clearing cycle is kept, so none is lost.
    nxt_conflict_sticky = nxt_conflict_sticky | conflict_now;
  end

  // ========================================================================
  // State and register flops.
  // ========================================================================
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_data_latch_ff <= `GPW_RST_DATA;
      pin_direction_ctrl_ff <= `GPW_RST_DIR;
      pin_pullup_ctrl_ff <= `GPW_RST_PULLUP;
      pin_function_select_ff <= `GPW_RST_FUNC;
      conflict_sticky_ff <= `GPW_RST_CONFLICT;
      state_ff <= ST_IDLE;
    end else begin
      pin_data_latch_ff <= nxt_pin_data_latch;
      pin_direction_ctrl_ff <= nxt_pin_direction_ctrl;
      pin_pullup_ctrl_ff <= nxt_pin_pullup_ctrl;
      pin_function_select_ff <= nxt_pin_function_select;
      conflict_sticky_ff <= nxt_conflict_sticky;
      state_ff <= nxt_state;
    end
  end

  // ========================================================================
  // Bus answer flops.
  // ========================================================================

  // Read data is captured only when an answer is prepared for a read, and held otherwise.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `GPW_RDATA_ZERO;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= nxt_pready;
      pslverr <= nxt_pslverr;
      if (nxt_pready && !pwrite) begin
        prdata <= nxt_prdata;
      end
    end
  end

  // ========================================================================
  // Pin-side output flops.
  // ========================================================================

  // Registering the pin controls costs one cycle of latency after a write but
  // keeps glitches from decode off the board.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gp_pin_n_out <= {PORT_W{1'b0}};
      gp_pin_n_oe <= {PORT_W{1'b0}};
      pullup_en <= {PORT_W{1'b0}};
      wake_input_n <= `GPW_WAKE_IDLE;
    end else begin
      gp_pin_n_out <= cell_out;
      gp_pin_n_oe <= cell_oe;
      pullup_en <= cell_pullup;
      wake_input_n <= cell_wake;
    end
  end

endmodule // gpw_port

// *** dv/gpw_props.sv ***
`timescale 1ns/1ps
`include "gpw_map.vh"

// ==========================================================================
// Port checker
// ==========================================================================
module gpw_props #(
  parameter PORT_W = 8,
  parameter ADDR_W = 12
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [PORT_W-1:0] gp_pin_n_in,
  input wire [PORT_W-1:0] gp_pin_n_out,
  input wire [PORT_W-1:0] gp_pin_n_oe,
  input wire [PORT_W-1:0] pullup_en,
  input wire [PORT_W-1:0] wake_input_n
);
  reg [PORT_W-1:0] dir_ff, lat_ff, pu_ff, fn_ff;
  wire wr = psel & penable & pready & pwrite & pstrb[0] & ~pslverr;
  wire rd = psel & ~penable & ~pwrite;

  // Shadow copy of the settings; only completed error-free writes land.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_ff <= 0;
      lat_ff <= 0;
      pu_ff <= 0;
      fn_ff <= 0;
    end else if (wr) begin
      if (paddr == `GPW_OFF_DIR) dir_ff <= pwdata[PORT_W-1:0];
      if (paddr == `GPW_OFF_DATA) lat_ff <= pwdata[PORT_W-1:0];
      if (paddr == `GPW_OFF_PULLUP) pu_ff <= pwdata[PORT_W-1:0];
      if (paddr == `GPW_OFF_FUNC) fn_ff <= pwdata[PORT_W-1:0];
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Pin outputs trail the settings by one edge, hence the past values.
  data_read_a: assert property (rd && paddr == `GPW_OFF_DATA |=> pready &&
    prdata[PORT_W-1:0] == ($past(dir_ff) & $past(lat_ff) | ~$past(dir_ff) & $past(gp_pin_n_in)))
    else $error("Data read wrong.");
  dir_read_a: assert property (rd && paddr == `GPW_OFF_DIR |=> prdata[PORT_W-1:0] == {PORT_W{1'b1}})
    else $error("Direction read wrong.");
  drive_en_a: assert property (gp_pin_n_oe == ($past(dir_ff) & ~$past(fn_ff)))
    else $error("Driver enable wrong.");
  drive_val_a: assert property (gp_pin_n_out == ($past(dir_ff) & ~$past(fn_ff) & $past(lat_ff)))
    else $error("Driven value wrong.");
  pullup_a: assert property (pullup_en == (~$past(dir_ff) & $past(pu_ff)))
    else $error("Pull-up wrong.");
  wake_fwd_a: assert property (wake_input_n == (~$past(fn_ff) | $past(gp_pin_n_in)))
    else $error("Wake level wrong.");
  wake_idle_a: assert property (fn_ff == 0 |=> wake_input_n == {PORT_W{1'b1}})
    else $error("Wake line not idle.");
  wake_no_drive_a: assert property ((gp_pin_n_oe & $past(fn_ff)) == 0)
    else $error("Wake pin driven.");
  pullup_rst_a: assert property ($rose(presetn) |-> pullup_en == 0)
    else $error("Pull-up on after reset.");

  cover property (rd && paddr == `GPW_OFF_DATA && dir_ff != 0 && dir_ff != {PORT_W{1'b1}});
  cover property (fn_ff != 0 ##1 wake_input_n != {PORT_W{1'b1}});
  cover property (pullup_en != 0);
endmodule // gpw_props

// *** dv/gpw_board.sv ***
`timescale 1ns/1ps

// ==========================================================================
// Board side of the pins
// ==========================================================================
module gpw_board (
  input wire pclk,
  input wire [7:0] oe,
  input wire [7:0] out,
  input wire [7:0] pu,
  input wire [7:0] ext,
  input wire [7:0] ext_en,
  output wire [7:0] lvl
);
  reg [7:0] pat_ff = 8'h5a;

  // A floating line wanders, so a read never sees a steady guess.
  always @(posedge pclk) pat_ff <= pat_ff + 8'h3b;

  // Device driver wins, then the board, then the pull-up.
  assign lvl = (oe & out) | (~oe & ext_en & ext) | (~oe & ~ext_en & (pu | pat_ff));
endmodule // gpw_board

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
`include "gpw_map.vh"

// ==========================================================================
// Port testbench
// ==========================================================================
module tb_top;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0;
  reg [3:0] pstrb = 4'hf;
  reg [7:0] ext = 0, ext_en = 8'hff;
  wire [31:0] prdata;
  wire pready, pslverr;
  wire [7:0] pin, dout, doe, pue, wk;
  int error_cnt = 0, samples_checked = 0;
  logic [31:0] rd;
  logic err;
  // Rows: dir, latch, pull-up, function, board level, then read, oe, out, pull-up, wake.
  logic [79:0] rows [5] = '{80'h0000_0000_a5a5_0000_00ff, 80'hff3c_ff00_0f3c_ff3c_00ff,
    80'h0faa_f000_555a_0f0a_f0ff, 80'h00ff_0ff0_3c3c_0000_0f3f, 80'h3fff_00c3_99bf_3c3c_00bd};

  gpw_port #(.PORT_W(8), .ADDR_W(12)) i_gpw_port (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .gp_pin_n_in(pin), .gp_pin_n_out(dout),
    .gp_pin_n_oe(doe), .pullup_en(pue), .wake_input_n(wk));
  gpw_board i_gpw_board (.pclk(pclk), .oe(doe), .out(dout), .pu(pue), .ext(ext), .ext_en(ext_en),
    .lvl(pin));

  // Free-running bus clock.
  initial forever #12.5 pclk = ~pclk;

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // One transfer, held until pready is seen at an edge; a hang is left to the watchdog.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask

  task tally_and_finish;
    $display("mismatches %0d comparisons %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Main sequence: table rows first, then the awkward cases.
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    chk("pullup", pue, 0);
    chk("oe", doe, 0);
    chk("wake", wk, 8'hff);
    for (int i = 0; i < 5; i++) begin
      apb(1, `GPW_OFF_DIR, rows[i][79:72]);
      apb(1, `GPW_OFF_DATA, rows[i][71:64]);
      apb(1, `GPW_OFF_PULLUP, rows[i][63:56]);
      apb(1, `GPW_OFF_FUNC, rows[i][55:48]);
      ext <= rows[i][47:40];
      repeat (3) @(posedge pclk);
      apb(0, `GPW_OFF_DATA, 0);
      chk("data", rd, rows[i][39:32]);
      chk("oe", doe, rows[i][31:24]);
      chk("out", dout, rows[i][23:16]);
      chk("pullup", pue, rows[i][15:8]);
      chk("wake", wk, rows[i][7:0]);
      apb(0, `GPW_OFF_DIR, 0);
      chk("dir", rd, 32'h0000_00ff);
    end
    apb(0, `GPW_OFF_FUNC, 0);
    chk("func", rd, 32'h0000_00c3);
    // Released high nibble must read as pulled up.
    apb(1, `GPW_OFF_FUNC, 0);
    apb(1, `GPW_OFF_DIR, 0);
    apb(1, `GPW_OFF_PULLUP, 32'h0000_00f0);
    ext_en <= 8'h0f;
    ext <= 8'h00;
    repeat (3) @(posedge pclk);
    apb(0, `GPW_OFF_DATA, 0);
    chk("data", rd, 32'h0000_00f0);
    apb(0, 12'h020, 0);
    chk("slverr", err, 1);
    // Raw pin levels are visible whatever the direction bits say.
    apb(0, `GPW_OFF_PIN_LEVEL, 0);
    chk("pin level", rd, 32'h0000_00f0);
    // A write without byte lane zero must leave the register alone.
    pstrb <= 4'he;
    apb(1, `GPW_OFF_PULLUP, 0);
    pstrb <= 4'hf;
    apb(0, `GPW_OFF_PULLUP, 0);
    chk("pu strobe", rd, 32'h0000_00f0);
    // The last row mixed output and wake on pins 5:4, then on pins 1:0.
    apb(0, `GPW_OFF_CONFLICT, 0);
    chk("conflict", rd, 32'h0000_0033);
    // A clear while the mix persists must lose to the set.
    apb(1, `GPW_OFF_DIR, 32'h0000_0001);
    apb(1, `GPW_OFF_FUNC, 32'h0000_0001);
    apb(1, `GPW_OFF_CONFLICT, 32'h0000_00ff);
    apb(0, `GPW_OFF_CONFLICT, 0);
    chk("conflict", rd, 32'h0000_0001);
    chk("oe", doe, 0);
    // Mid-run reset drops the pull-ups at once.
    presetn <= 0;
    repeat (2) @(posedge pclk);
    chk("pullup", pue, 0);
    presetn <= 1;
    @(posedge pclk);
    apb(0, `GPW_OFF_PULLUP, 0);
    chk("pu reg", rd, 0);
    tally_and_finish;
  end

  // Watchdog well beyond the 170 or so cycles the sequence needs.
  initial begin
    #50000;
    error_cnt++;
    tally_and_finish;
  end
endmodule // tb_top

bind gpw_port gpw_props #(.PORT_W(PORT_W), .ADDR_W(ADDR_W)) u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .gp_pin_n_in(gp_pin_n_in),
  .gp_pin_n_out(gp_pin_n_out), .gp_pin_n_oe(gp_pin_n_oe), .pullup_en(pullup_en),
  .wake_input_n(wake_input_n));
